// *** hw/smlu_mac_long.sv ***
`default_nettype none
`include "smlu_defines.svh"

// Operation
// - word form: signed 32x32 product plus 64-bit accumulator, returned as 64 bits
// - result split: low word to acc_low_reg, upper word to acc_high_reg
// - halfword forms: first selector picks bits 15:0 for bottom, 31:16 for top
// - halfword forms: second selector picks bits 15:0 for bottom, 31:16 for top
// - halfword forms: signed 16x16 product sign-extended to 64 bits, then accumulated
// - halfword forms: unselected halfwords have no effect on the result
// - uncrossed dual: signed halfword pairs, top times top and bottom times bottom
// - crossed dual: first bottom times second top, first top times second bottom
module smlu_mac_long
  import smlu_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    start_i,
  input  wire smlu_op_t                op_i,
  input  wire logic [`SMLU_WORD_W-1:0] first_operand_reg_i,
  input  wire logic [`SMLU_WORD_W-1:0] second_operand_reg_i,
  input  wire logic [`SMLU_WORD_W-1:0] acc_low_reg_i,
  input  wire logic [`SMLU_WORD_W-1:0] acc_high_reg_i,
  output logic                         done_o,
  output logic                         op_error_o,
  output logic [`SMLU_WORD_W-1:0]      acc_low_reg_o,
  output logic [`SMLU_WORD_W-1:0]      acc_high_reg_o
);

  smlu_state_t                     state_q;
  smlu_state_t                     state_d;
  logic [`SMLU_ACC_W-1:0]          res_q;
  logic [`SMLU_ACC_W-1:0]          res_d;
  logic                            err_q;
  logic                            err_d;
  logic                            op_legal;
  logic                            word_form;

  logic signed [`SMLU_HALF_W-1:0]  n_lo;
  logic signed [`SMLU_HALF_W-1:0]  n_hi;
  logic signed [`SMLU_HALF_W-1:0]  m_lo;
  logic signed [`SMLU_HALF_W-1:0]  m_hi;
  logic signed [`SMLU_HALF_W-1:0]  a0;
  logic signed [`SMLU_HALF_W-1:0]  b0;
  logic signed [`SMLU_HALF_W-1:0]  a1;
  logic signed [`SMLU_HALF_W-1:0]  b1;
  logic                            en0;
  logic                            en1;
  logic signed [`SMLU_ACC_W-1:0]   p0;
  logic signed [`SMLU_ACC_W-1:0]   p1;
  logic signed [`SMLU_ACC_W-1:0]   word_prod;
  logic [`SMLU_ACC_W-1:0]          acc_in;
  logic [`SMLU_ACC_W-1:0]          sum;

  // halfword split of both operands
  always_comb begin
    n_lo   = first_operand_reg_i[`SMLU_HALF_LO +: `SMLU_HALF_W];
    n_hi   = first_operand_reg_i[`SMLU_HALF_HI +: `SMLU_HALF_W];
    m_lo   = second_operand_reg_i[`SMLU_HALF_LO +: `SMLU_HALF_W];
    m_hi   = second_operand_reg_i[`SMLU_HALF_HI +: `SMLU_HALF_W];
    acc_in = {acc_high_reg_i, acc_low_reg_i};
  end

  // op decode; code 7 is the only one outside the set
  always_comb begin
    op_legal  = 1'b1;
    word_form = 1'b0;
    unique case (op_i)
      signed_word_mac_long: begin
        word_form = 1'b1;
      end
      halfword_mac_long_bottom_bottom,
      halfword_mac_long_bottom_top,
      halfword_mac_long_top_bottom,
      halfword_mac_long_top_top,
      dual_halfword_mac_long,
      dual_halfword_mac_long_crossed: begin
        word_form = 1'b0;
      end
      default: begin
        op_legal = 1'b0;
      end
    endcase
  end

  // every halfword and dual form names its halfwords, so an unselected half never reaches a live lane
  always_comb begin
    a0  = n_lo;
    b0  = m_lo;
    a1  = n_hi;
    b1  = m_hi;
    en0 = 1'b0;
    en1 = 1'b0;
    unique case (op_i)
      signed_word_mac_long: begin
        en0 = 1'b0;
        en1 = 1'b0;
      end
      halfword_mac_long_bottom_bottom: begin
        a0  = n_lo;
        b0  = m_lo;
        en0 = 1'b1;
      end
      halfword_mac_long_bottom_top: begin
        a0  = n_lo;
        b0  = m_hi;
        en0 = 1'b1;
      end
      halfword_mac_long_top_bottom: begin
        a0  = n_hi;
        b0  = m_lo;
        en0 = 1'b1;
      end
      halfword_mac_long_top_top: begin
        a0  = n_hi;
        b0  = m_hi;
        en0 = 1'b1;
      end
      dual_halfword_mac_long: begin
        a0  = n_hi;
        b0  = m_hi;
        a1  = n_lo;
        b1  = m_lo;
        en0 = 1'b1;
        en1 = 1'b1;
      end
      dual_halfword_mac_long_crossed: begin
        a0  = n_lo;
        b0  = m_hi;
        a1  = n_hi;
        b1  = m_lo;
        en0 = 1'b1;
        en1 = 1'b1;
      end
      default: begin
        en0 = 1'b0;
        en1 = 1'b0;
      end
    endcase
  end

  // second lane only used by the dual forms; halfword forms leave it off through the en1 default of 0
  smlu_half_mul u_lane0 (
    .a_i    (a0),
    .b_i    (b0),
    .en_i   (en0),
    .prod_o (p0)
  );

  smlu_half_mul u_lane1 (
    .a_i    (a1),
    .b_i    (b1),
    .en_i   (en1),
    .prod_o (p1)
  );

  // word form uses the full 32x32 product; both lanes stay gated off for it
  always_comb begin
    word_prod = $signed(first_operand_reg_i) * $signed(second_operand_reg_i);
  end

  // plain 64-bit add: carries out of bit 63 are dropped, never saturated
  always_comb begin
    if (word_form) begin
      sum = acc_in + word_prod;
    end else begin
      sum = acc_in + p0 + p1;
    end
  end

  // status group: one-cycle latency, a new start may follow every cycle
  always_comb begin
    state_d = state_q;
    err_d   = err_q;
    unique case (state_q)
      SMLU_IDLE,
      SMLU_DONE: begin
        if (start_i) begin
          state_d = SMLU_DONE;
          err_d   = ~op_legal;
        end else begin
          state_d = SMLU_IDLE;
          err_d   = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SMLU_IDLE;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      err_q   <= err_d;
    end
  end

  // result group: holds between requests so the core may pick it up late
  always_comb begin
    res_d = res_q;
    if (start_i) begin
      // illegal code keeps the accumulator unchanged rather than guessing
      res_d = op_legal ? sum : acc_in;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_q <= `SMLU_ACC_RST;
    end else begin
      res_q <= res_d;
    end
  end

  always_comb begin
    done_o         = (state_q == SMLU_DONE);
    op_error_o     = err_q;
    acc_low_reg_o  = res_q[`SMLU_WORD_W-1:0];
    acc_high_reg_o = res_q[`SMLU_ACC_W-1:`SMLU_WORD_W];
  end

endmodule : smlu_mac_long

`default_nettype wire

// *** hw/smlu_defines.svh ***
`ifndef SMLU_DEFINES_SVH
`define SMLU_DEFINES_SVH

`define SMLU_WORD_W   32
`define SMLU_HALF_W   16
`define SMLU_ACC_W    64
`define SMLU_HALF_LO  0
`define SMLU_HALF_HI  16
`define SMLU_OP_W     3
`define SMLU_ACC_RST  64'h0000_0000_0000_0000

`endif

// *** hw/smlu_pkg.sv ***
`default_nettype none
`include "smlu_defines.svh"

package smlu_pkg;

  typedef enum logic [2:0] {
    signed_word_mac_long            = 3'h0,
    halfword_mac_long_bottom_bottom = 3'h1,
    halfword_mac_long_bottom_top    = 3'h2,
    halfword_mac_long_top_bottom    = 3'h3,
    halfword_mac_long_top_top       = 3'h4,
    dual_halfword_mac_long          = 3'h5,
    dual_halfword_mac_long_crossed  = 3'h6
  } smlu_op_t;

  typedef enum logic [0:0] {
    SMLU_IDLE = 1'b0,
    SMLU_DONE = 1'b1
  } smlu_state_t;

endpackage : smlu_pkg

`default_nettype wire

// *** hw/smlu_half_mul.sv ***
`default_nettype none
`include "smlu_defines.svh"

// signed 16x16 multiplier, product sign-extended to the accumulator width
module smlu_half_mul (
  input  wire logic signed [`SMLU_HALF_W-1:0] a_i,
  input  wire logic signed [`SMLU_HALF_W-1:0] b_i,
  input  wire logic                           en_i,
  output logic signed [`SMLU_ACC_W-1:0]       prod_o
);

  logic signed [`SMLU_WORD_W-1:0] prod32;

  always_comb begin
    prod32 = a_i * b_i;
    // gated so an unused lane adds nothing
    prod_o = en_i ? `SMLU_ACC_W'(prod32) : '0;
  end

endmodule : smlu_half_mul

`default_nettype wire

// *** sim/smlu_properties.sv ***
`default_nettype none
module smlu_chk
  import smlu_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        start_i,
  input wire smlu_op_t    op_i,
  input wire logic [31:0] first_operand_reg_i,
  input wire logic [31:0] second_operand_reg_i,
  input wire logic [31:0] acc_low_reg_i,
  input wire logic [31:0] acc_high_reg_i,
  input wire logic        done_o,
  input wire logic        op_error_o,
  input wire logic [31:0] acc_low_reg_o,
  input wire logic [31:0] acc_high_reg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic signed [15:0] at, ab, bt, bb;
  logic signed [63:0] ex;
  logic        [63:0] res;
  always_comb begin
    {at, ab} = first_operand_reg_i;
    {bt, bb} = second_operand_reg_i;
    res = {acc_high_reg_o, acc_low_reg_o};
    ex = {acc_high_reg_i, acc_low_reg_i};
    case (op_i)
      3'h0: ex = ex + $signed(first_operand_reg_i) * $signed(second_operand_reg_i);
      3'h1: ex = ex + ab * bb;
      3'h2: ex = ex + ab * bt;
      3'h3: ex = ex + at * bb;
      3'h4: ex = ex + at * bt;
      3'h5: ex = ex + at * bt + ab * bb;
      3'h6: ex = ex + ab * bt + at * bb;
      default: ;
    endcase
  end
  a_word_sum: assert property (start_i && op_i == 3'h0 |=> res == $past(ex))
    else $error("word sum wrong");
  a_half_sum: assert property (start_i && op_i inside {[3'h1:3'h4]} |=> res == $past(ex))
    else $error("halfword sum wrong");
  a_dual_sum: assert property (start_i && op_i inside {3'h5, 3'h6} |=> res == $past(ex))
    else $error("dual sum wrong");
  a_split_high: assert property (start_i |=> acc_high_reg_o == 32'($past(ex) >> 32))
    else $error("high word wrong");
  a_done_next: assert property (start_i |=> done_o)
    else $error("done missing");
  a_done_idle: assert property (!start_i |=> !done_o)
    else $error("done without request");
  a_err_flag: assert property (start_i |=> op_error_o == ($past(op_i) == 3'h7))
    else $error("error flag wrong");
  a_bad_keeps: assert property (start_i && op_i == 3'h7 |=> res == $past(ex))
    else $error("illegal op moved the accumulator");
  a_hold_idle: assert property (!start_i |=> $stable(res))
    else $error("result moved while idle");
  c_crossed: cover property (start_i && op_i == 3'h6);
  c_back: cover property (start_i ##1 start_i);
  c_bad_op: cover property (start_i && op_i == 3'h7);
endmodule : smlu_chk
bind smlu_mac_long smlu_chk u_chk (.*);
`default_nettype wire

// *** sim/smlu_core_model.sv ***
`default_nettype none
module smlu_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        done_i,
  input  wire logic [31:0] lo_i,
  input  wire logic [31:0] hi_i,
  output logic [31:0]      lo_o,
  output logic [31:0]      hi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] acc_d, acc_q;
  // forwarding so back-to-back ops see the newest sum
  always_comb begin
    acc_d = done_i ? {hi_i, lo_i} : acc_q;
    {hi_o, lo_o} = acc_d;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      acc_q <= 64'h0;
    else
      acc_q <= acc_d;
  end
endmodule : smlu_core_model
`default_nettype wire

// *** sim/signed_mac_long_unit_tb.sv ***
`default_nettype none
module signed_mac_long_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smlu_pkg::*;
  logic        clk_sys_i, rst_n_i, start_i, done_o, op_error_o;
  smlu_op_t    op_i;
  logic [31:0] fa, fb, al, ah, rl, rh;
  logic [63:0] exp;
  int          failures, checked;
  smlu_mac_long dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .first_operand_reg_i(fa), .second_operand_reg_i(fb), .acc_low_reg_i(al), .acc_high_reg_i(ah),
    .done_o(done_o), .op_error_o(op_error_o), .acc_low_reg_o(rl), .acc_high_reg_o(rh));
  smlu_core_model core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .done_i(done_o),
    .lo_i(rl), .hi_i(rh), .lo_o(al), .hi_o(ah));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task chk(string n, logic [64:0] e, logic [64:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // start stays high so calls in a row are back to back
  task run(logic [2:0] o, logic [31:0] x, logic [31:0] y, logic [63:0] p);
    op_i = smlu_op_t'(o);
    fa = x;
    fb = y;
    start_i = 1'b1;
    exp = exp + p;
    @(posedge clk_sys_i);
    #1;
    chk("result", {1'b1, exp}, {done_o, rh, rl});
    chk("error", 65'(o == 3'h7), 65'(op_error_o));
  endtask : run
  task idle(string n);
    start_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk("idle", {1'b0, exp}, {done_o, rh, rl});
    chk("idle error", 65'h0, 65'(op_error_o));
    $display("test %s done", n);
  endtask : idle
  // mid-run reset clears the result at once, without waiting for a clock
  task t_reset;
    run(3'h0, 32'h5, 32'h7, 64'h23);
    rst_n_i = 1'b0;
    start_i = 1'b0;
    exp = 64'h0;
    #1;
    chk("async reset", 65'h0, {done_o, rh, rl});
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    run(3'h4, 32'hfffe0000, 32'h00030000, -64'h6);
    idle("reset");
  endtask : t_reset
  task t_word;
    run(3'h0, 32'hfffffffe, 32'h3, -64'h6);
    repeat (4) run(3'h0, 32'h80000000, 32'h80000000, 64'h4000000000000000);
    idle("word");
  endtask : t_word
  task t_half;
    run(3'h1, 32'h7fff0002, 32'h8000fffd, -64'h6);
    run(3'h2, 32'h12340003, 32'hfffe5555, -64'h6);
    run(3'h3, 32'h0004aaaa, 32'h99990003, 64'hc);
    run(3'h4, 32'h80000000, 32'h80007fff, 64'h40000000);
    idle("half");
  endtask : t_half
  task t_dual;
    run(3'h5, 32'h00020003, 32'h0005fff9, -64'hb);
    run(3'h6, 32'h00020003, 32'h0005fff9, 64'h1);
    run(3'h5, 32'h80008000, 32'h80008000, 64'h80000000);
    run(3'h7, 32'h11111111, 32'h22222222, 64'h0);
    idle("dual");
  endtask : t_dual
  task conclude;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    op_i = signed_word_mac_long;
    fa = 32'h0;
    fb = 32'h0;
    exp = 64'h0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("reset", 65'h0, {done_o, rh, rl});
    chk("reset error", 65'h0, 65'(op_error_o));
    rst_n_i = 1'b1;
    t_word();
    t_half();
    t_dual();
    t_reset();
    conclude();
  end
  // about 25 cycles of tests, so 2000 is ample
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    failures++;
    conclude();
  end
endmodule : signed_mac_long_unit_tb
`default_nettype wire
